/* File: design/pdl_pkg.sv */
package pdl_pkg;

  // ----------------------------------------------------------------
  // Register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0]  REG_DIAG   = 5'h12;
  localparam logic [4:0]  REG_GAIN   = 5'h13;
  localparam logic [4:0]  REG_LED    = 5'h17;
  localparam logic [4:0]  REG_XOVER  = 5'h18;
  localparam logic [15:0] DIAG_RST   = 16'h0000;
  localparam logic [15:0] GAIN_RST   = 16'h4000;
  localparam logic [15:0] LED_RST    = 16'h0010;
  localparam logic [15:0] XOVER_RST  = 16'h00c0;
  localparam logic [15:0] ZERO_WORD  = 16'h0000;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int          DIAG_FAIL_BIT = 12;
  localparam int          DIAG_FDX_BIT   = 11;
  localparam int          DIAG_RATE_BIT  = 10;
  localparam int          DIAG_RXDET_BIT = 9;
  localparam int          DIAG_LOCK_BIT = 8;
  localparam logic [15:0] DIAG_RSV_MASK = 16'he0ff;
  localparam logic [15:0] GAIN_WMASK    = 16'hc000;
  localparam int          GAIN_MSB      = 15;
  localparam int          GAIN_LSB      = 14;
  localparam int          LED_SEL_W     = 4;

  // ----------------------------------------------------------------
  // LED source codes
  // ----------------------------------------------------------------
  localparam logic [3:0] LED_LINK  = 4'h0;
  localparam logic [3:0] LED_ACT   = 4'h1;
  localparam logic [3:0] LED_100   = 4'h5;
  localparam logic [3:0] LED_10    = 4'h6;
  localparam logic [3:0] LED_FDX   = 4'h7;
  localparam logic [3:0] LED_BLINK = 4'h8;

  // ----------------------------------------------------------------
  // Management frame
  // ----------------------------------------------------------------
  localparam logic [5:0] PRE_LEN  = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0d;
  localparam logic [5:0] DAT_LAST = 6'h0f;
  localparam logic [5:0] TA_LAST  = 6'h01;
  localparam logic [5:0] CNT_ONE  = 6'h01;
  localparam logic [1:0] FR_START = 2'b01;
  localparam logic [1:0] OP_RD    = 2'b10;
  localparam logic [1:0] OP_WR    = 2'b01;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int BLINK_HALF_NS = 50_000_000;

  typedef enum logic [2:0] {ST_PRE, ST_HDR, ST_TA, ST_RD, ST_WR} pdl_state_e;

  typedef struct packed {
    logic full_duplex;
    logic rate_100;
    logic rx_detect;
    logic rx_lock;
  } pdl_an_stat_s;

  typedef struct packed {
    logic link_ok;
    logic activity;
    logic mode_100;
    logic mode_10;
    logic full_duplex;
  } pdl_led_src_s;

endpackage

/* File: design/pdl_regs.sv */
module pdl_regs
  import pdl_pkg::*;
#(
  parameter int BLINK_CYCLES = BLINK_HALF_NS / CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_resetn,
  // Management interface
  input  wire logic         i_mdc,
  input  wire logic         i_mdio,
  output logic              o_mdio,
  output logic              o_mdio_oe,
  input  wire logic [4:0]   i_phy_addr,
  // Negotiation and receive status
  input  wire logic         i_an_fail_evt,
  input  wire pdl_an_stat_s i_an_stat,
  // LED sources and outputs
  input  wire pdl_led_src_s i_led_src,
  output logic              o_first_led,
  output logic              o_second_led,
  // Analog and mux control
  output logic [1:0]        o_tx_gain,
  output logic [15:0]       o_xover_ctrl
);

  // ----------------------------------------------------------------
  // LED source decode
  // ----------------------------------------------------------------
  function automatic logic led_decode(input logic [3:0] sel,
                                      input pdl_led_src_s src,
                                      input logic phase);
    logic on;
    on = 1'b0;
    case (sel)
      LED_LINK:  on = src.link_ok;
      LED_ACT:   on = src.activity;
      LED_100:   on = src.mode_100;
      LED_10:    on = src.mode_10;
      LED_FDX:   on = src.full_duplex;
      LED_BLINK: on = src.link_ok & ~(src.activity & phase);
      default:   on = 1'b0;
    endcase
    return on;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pdl_state_e  st_r,      st_nxt;
  logic [5:0]  cnt_r,     cnt_nxt;
  logic [15:0] sh_r,      sh_nxt;
  logic [4:0]  reg_r,     reg_nxt;
  logic        rd_r,      rd_nxt;
  logic        mdc_r;
  logic        mdo_r,     mdo_nxt;
  logic        mdoe_r,    mdoe_nxt;
  logic        fail_r,    fail_nxt;
  logic [15:0] gain_r,    gain_nxt;
  logic [7:0]  led_r,     led_nxt;
  logic [15:0] xover_r,   xover_nxt;
  logic [15:0] rd_word;
  logic        mdc_rise;
  logic        rd_load;
  logic        wr_done;
  logic        fail_clr;

  assign mdc_rise = i_mdc & ~mdc_r;
  assign rd_load  = mdc_rise && st_r == ST_TA && cnt_r == TA_LAST && rd_r;
  assign wr_done  = mdc_rise && st_r == ST_WR && cnt_r == DAT_LAST;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = ZERO_WORD;
    unique case (reg_r)
      REG_DIAG: begin
        rd_word[DIAG_FAIL_BIT] = fail_r;
        rd_word[DIAG_FDX_BIT]   = i_an_stat.full_duplex;
        rd_word[DIAG_RATE_BIT]  = i_an_stat.rate_100;
        rd_word[DIAG_RXDET_BIT] = i_an_stat.rx_detect;
        rd_word[DIAG_LOCK_BIT] = i_an_stat.rx_lock;
      end
      REG_GAIN:  rd_word = gain_r;
      REG_LED:   rd_word = {8'h00, led_r};
      REG_XOVER: rd_word = xover_r;
      default:   rd_word = ZERO_WORD;
    endcase
  end

  // ----------------------------------------------------------------
  // Frame engine and register file
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    sh_nxt    = sh_r;
    reg_nxt   = reg_r;
    rd_nxt    = rd_r;
    mdo_nxt   = mdo_r;
    mdoe_nxt  = mdoe_r;
    gain_nxt  = gain_r;
    led_nxt   = led_r;
    xover_nxt = xover_r;
    fail_clr  = 1'b0;
    if (mdc_rise) begin
      unique case (st_r)
        ST_PRE: begin
          // A zero after a full preamble is the first start bit
          if (i_mdio) begin
            cnt_nxt = (cnt_r == PRE_LEN) ? cnt_r : cnt_r + CNT_ONE;
          end else if (cnt_r == PRE_LEN) begin
            st_nxt  = ST_HDR;
            sh_nxt  = ZERO_WORD;
            cnt_nxt = CNT_ONE;
          end else begin
            cnt_nxt = '0;
          end
        end
        ST_HDR: begin
          sh_nxt  = {sh_r[14:0], i_mdio};
          cnt_nxt = cnt_r + CNT_ONE;
          if (cnt_r == HDR_LAST) begin
            cnt_nxt = '0;
            reg_nxt = sh_nxt[4:0];
            rd_nxt  = sh_nxt[11:10] == OP_RD;
            // Frames for another address are ignored whole
            if (sh_nxt[13:12] == FR_START && sh_nxt[9:5] == i_phy_addr &&
                (sh_nxt[11:10] == OP_RD || sh_nxt[11:10] == OP_WR)) begin
              st_nxt = ST_TA;
            end else begin
              st_nxt = ST_PRE;
            end
          end
        end
        ST_TA: begin
          cnt_nxt = cnt_r + CNT_ONE;
          if (cnt_r != TA_LAST) begin
            mdo_nxt  = 1'b0;
            mdoe_nxt = rd_r;
          end else if (rd_r) begin
            st_nxt   = ST_RD;
            cnt_nxt  = '0;
            sh_nxt   = rd_word;
            mdo_nxt  = rd_word[15];
            mdoe_nxt = 1'b1;
            fail_clr = reg_r == REG_DIAG;
          end else begin
            st_nxt  = ST_WR;
            cnt_nxt = '0;
          end
        end
        ST_RD: begin
          if (cnt_r == DAT_LAST) begin
            st_nxt   = ST_PRE;
            cnt_nxt  = '0;
            mdoe_nxt = 1'b0;
          end else begin
            sh_nxt  = {sh_r[14:0], 1'b0};
            mdo_nxt = sh_r[14];
            cnt_nxt = cnt_r + CNT_ONE;
          end
        end
        ST_WR: begin
          sh_nxt  = {sh_r[14:0], i_mdio};
          cnt_nxt = cnt_r + CNT_ONE;
          if (cnt_r == DAT_LAST) begin
            st_nxt  = ST_PRE;
            cnt_nxt = '0;
            // Diagnostic and unmapped addresses drop writes
            case (reg_r)
              REG_GAIN:  gain_nxt  = sh_nxt & GAIN_WMASK;
              REG_LED:   led_nxt   = sh_nxt[7:0];
              REG_XOVER: xover_nxt = sh_nxt;
              default:   ;
            endcase
          end
        end
      endcase
    end
    // New failure wins over a same-cycle read clear
    fail_nxt = i_an_fail_evt | (fail_r & ~fail_clr);
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r    <= ST_PRE;
      cnt_r   <= '0;
      sh_r    <= ZERO_WORD;
      reg_r   <= '0;
      rd_r    <= 1'b0;
      mdc_r   <= 1'b0;
      mdo_r   <= 1'b0;
      mdoe_r  <= 1'b0;
      fail_r  <= DIAG_RST[DIAG_FAIL_BIT];
      gain_r  <= GAIN_RST;
      led_r   <= LED_RST[7:0];
      xover_r <= XOVER_RST;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      reg_r   <= reg_nxt;
      rd_r    <= rd_nxt;
      mdc_r   <= i_mdc;
      mdo_r   <= mdo_nxt;
      mdoe_r  <= mdoe_nxt;
      fail_r  <= fail_nxt;
      gain_r  <= gain_nxt;
      led_r   <= led_nxt;
      xover_r <= xover_nxt;
    end
  end

  assign o_mdio       = mdo_r;
  assign o_mdio_oe    = mdoe_r;
  assign o_tx_gain    = gain_r[GAIN_MSB:GAIN_LSB];
  assign o_xover_ctrl = xover_r;

  // ----------------------------------------------------------------
  // LED drive
  // ----------------------------------------------------------------
  logic [31:0] blink_r,      blink_nxt;
  logic        phase_r,      phase_nxt;
  logic        first_led_r,  first_led_nxt;
  logic        second_led_r, second_led_nxt;

  always_comb begin
    blink_nxt = blink_r + 32'h0000_0001;
    phase_nxt = phase_r;
    if (blink_r >= 32'(BLINK_CYCLES - 1)) begin
      blink_nxt = '0;
      phase_nxt = ~phase_r;
    end
    first_led_nxt  = led_decode(led_r[3:0], i_led_src, phase_r);
    second_led_nxt = led_decode(led_r[7:4], i_led_src, phase_r);
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      blink_r      <= '0;
      phase_r      <= 1'b0;
      first_led_r  <= 1'b0;
      second_led_r <= 1'b0;
    end else begin
      blink_r      <= blink_nxt;
      phase_r      <= phase_nxt;
      first_led_r  <= first_led_nxt;
      second_led_r <= second_led_nxt;
    end
  end

  assign o_first_led  = first_led_r;
  assign o_second_led = second_led_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  fail_set_a: assert property (
    i_an_fail_evt |=> fail_r ##0 (rd_word[DIAG_FAIL_BIT] || reg_r != REG_DIAG))
    else $error("fail flag not set by event");
  fail_clear_a: assert property (
    rd_load && reg_r == REG_DIAG && !i_an_fail_evt |=> !fail_r)
    else $error("fail flag not cleared by read");
  diag_duplex_a: assert property (
    rd_load && reg_r == REG_DIAG
      |=> sh_r[DIAG_FDX_BIT] == $past(i_an_stat.full_duplex))
    else $error("duplex bit wrong");
  diag_rxdet_a: assert property (
    rd_load && reg_r == REG_DIAG
      |=> sh_r[DIAG_RXDET_BIT] == $past(i_an_stat.rx_detect))
    else $error("receive detect bit wrong");
  diag_rate_a: assert property (
    rd_load && reg_r == REG_DIAG
      |=> sh_r[DIAG_RATE_BIT] == $past(i_an_stat.rate_100)
          && sh_r[DIAG_LOCK_BIT] == $past(i_an_stat.rx_lock))
    else $error("rate or lock bit wrong");
  diag_rsv_a: assert property (
    rd_load && reg_r == REG_DIAG |=> (sh_r & DIAG_RSV_MASK) == ZERO_WORD)
    else $error("diagnostic reserved bits not zero");
  gain_rsv_a: assert property (
    (gain_r & ~GAIN_WMASK) == ZERO_WORD)
    else $error("gain reserved bits not zero");
  led_act_a: assert property (
    led_r[7:4] == LED_ACT && $stable(led_r)
      |=> o_second_led == $past(i_led_src.activity))
    else $error("second LED not showing activity");
  led_rsv_a: assert property (
    led_r[3:0] > LED_BLINK || (led_r[3:0] > LED_ACT && led_r[3:0] < LED_100)
      |=> !o_first_led)
    else $error("reserved LED code drives LED");
  xover_wr_a: assert property (
    wr_done && reg_r == REG_XOVER
      |=> xover_r == $past(sh_nxt)
          ##1 ($stable(o_xover_ctrl) || st_r != ST_PRE))
    else $error("crossover write lost");

endmodule

/* File: sim/pdl_mac_model.sv */
module pdl_mac_model
  import pdl_pkg::*;
(
  // Clock
  input  wire logic i_mclk,
  // Management wire
  output logic      o_mdc,
  output logic      o_mdio,
  output logic      o_mdio_oe,
  input  wire logic i_mdio
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
    o_mdio_oe = 1'b0;
  end

  // ----------------------------------------------------------------
  // Bit slot: drive in low phase, sample just before the rise
  // ----------------------------------------------------------------
  task automatic slot(input logic en, input logic b, output logic s);
    @(posedge i_mclk);
    o_mdc     <= 1'b0;
    o_mdio    <= b;
    o_mdio_oe <= en;
    repeat (3) @(posedge i_mclk);
    s = i_mdio;
    o_mdc <= 1'b1;
    repeat (2) @(posedge i_mclk);
  endtask

  task automatic header(input logic [1:0] op, input logic [4:0] pa,
                        input logic [4:0] ra);
    logic        s;
    logic [13:0] h;
    h = {FR_START, op, pa, ra};
    // No preamble suppression, so every frame pays 32 ones
    repeat (32) slot(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) slot(1'b1, h[i], s);
  endtask

  // Polled access by register address, no interrupt path
  task automatic mdio_read(input logic [4:0] pa, input logic [4:0] ra,
                           output logic [15:0] d);
    logic s;
    header(OP_RD, pa, ra);
    slot(1'b0, 1'b1, s);
    slot(1'b0, 1'b1, s);
    for (int i = 15; i >= 0; i--) begin
      slot(1'b0, 1'b1, s);
      d[i] = s;
    end
    slot(1'b0, 1'b1, s);
    @(posedge i_mclk);
    o_mdc <= 1'b0;
  endtask

  task automatic mdio_write(input logic [4:0] pa, input logic [4:0] ra,
                            input logic [15:0] d);
    logic s;
    header(OP_WR, pa, ra);
    slot(1'b1, 1'b1, s);
    slot(1'b1, 1'b0, s);
    for (int i = 15; i >= 0; i--) slot(1'b1, d[i], s);
    @(posedge i_mclk);
    o_mdc     <= 1'b0;
    o_mdio_oe <= 1'b0;
    repeat (2) @(posedge i_mclk);
  endtask
endmodule

/* File: sim/pdl_regs_tb.sv */
`define CHK(nm, e, g) \
  begin \
    checks++; \
    if ((g) !== (e)) begin \
      err_total++; \
      $display("unexpected %s: expected %h seen %h", nm, e, g); \
    end \
  end

module pdl_regs_tb;
  import pdl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [4:0] PHY_ADDR = 5'h05;

  logic         i_mclk;
  logic         i_resetn;
  logic         mdc;
  logic         mac_mdio;
  logic         mac_oe;
  logic         dev_mdio;
  logic         dev_oe;
  logic         mdio_w;
  logic         an_fail;
  pdl_an_stat_s an_stat;
  pdl_led_src_s led_src;
  logic         first_led;
  logic         second_led;
  logic [1:0]   tx_gain;
  logic [15:0]  xover;
  int           err_total;
  int           checks;

  // Released wire floats high through the pull-up
  assign mdio_w = dev_oe ? dev_mdio : (mac_oe ? mac_mdio : 1'b1);

  pdl_regs #(.BLINK_CYCLES(4)) uut (
    .i_mclk       (i_mclk),
    .i_resetn     (i_resetn),
    .i_mdc        (mdc),
    .i_mdio       (mdio_w),
    .o_mdio       (dev_mdio),
    .o_mdio_oe    (dev_oe),
    .i_phy_addr   (PHY_ADDR),
    .i_an_fail_evt(an_fail),
    .i_an_stat    (an_stat),
    .i_led_src    (led_src),
    .o_first_led  (first_led),
    .o_second_led (second_led),
    .o_tx_gain    (tx_gain),
    .o_xover_ctrl (xover)
  );

  pdl_mac_model mac (
    .i_mclk   (i_mclk),
    .o_mdc    (mdc),
    .o_mdio   (mac_mdio),
    .o_mdio_oe(mac_oe),
    .i_mdio   (mdio_w)
  );

  always #12.5 i_mclk = ~i_mclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] e);
    logic [15:0] d;
    mac.mdio_read(PHY_ADDR, ra, d);
    `CHK("read data", e, d)
  endtask

  function automatic logic led_exp(input logic [3:0] c,
                                   input pdl_led_src_s s);
    case (c)
      4'h0: return s.link_ok;
      4'h1: return s.activity;
      4'h5: return s.mode_100;
      4'h6: return s.mode_10;
      4'h7: return s.full_duplex;
      4'h8: return s.link_ok & ~s.activity;
      default: return 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_chk(REG_DIAG, 16'h0000);
    rd_chk(REG_GAIN, 16'h4000);
    rd_chk(REG_LED, 16'h0010);
    rd_chk(REG_XOVER, 16'h00c0);
    rd_chk(5'h1f, 16'h0000);
    `CHK("gain out", 2'b01, tx_gain)
    `CHK("xover out", 16'h00c0, xover)
  endtask

  task automatic t_write();
    mac.mdio_write(PHY_ADDR, REG_GAIN, 16'hffff);
    rd_chk(REG_GAIN, 16'hc000);
    `CHK("gain out", 2'b11, tx_gain)
    mac.mdio_write(PHY_ADDR, REG_LED, 16'hffff);
    rd_chk(REG_LED, 16'h00ff);
    mac.mdio_write(PHY_ADDR, REG_XOVER, 16'ha5a5);
    rd_chk(REG_XOVER, 16'ha5a5);
    `CHK("xover out", 16'ha5a5, xover)
    mac.mdio_write(PHY_ADDR, REG_DIAG, 16'hffff);
    rd_chk(REG_DIAG, 16'h0000);
    // Frame for another station must leave this one untouched
    mac.mdio_write(PHY_ADDR ^ 5'h01, REG_XOVER, 16'h1234);
    rd_chk(REG_XOVER, 16'ha5a5);
  endtask

  task automatic t_diag();
    @(posedge i_mclk);
    an_stat <= 4'b1010;
    rd_chk(REG_DIAG, 16'h0a00);
    @(posedge i_mclk);
    an_stat <= 4'b0101;
    rd_chk(REG_DIAG, 16'h0500);
    @(posedge i_mclk);
    an_fail <= 1'b1;
    @(posedge i_mclk);
    an_fail <= 1'b0;
    repeat (20) @(posedge i_mclk);
    rd_chk(REG_DIAG, 16'h1500);
    rd_chk(REG_DIAG, 16'h0500);
  endtask

  task automatic t_led();
    logic [3:0]   codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                                 4'h6, 4'h7, 4'h8, 4'h9, 4'hf};
    logic [3:0]   hi;
    pdl_led_src_s s;
    int           ones;
    for (int c = 0; c < 11; c++) begin
      hi = codes[(c + 3) % 11];
      mac.mdio_write(PHY_ADDR, REG_LED, {8'h00, hi, codes[c]});
      for (int b = 0; b < 5; b++) begin
        s = 5'b10000 >> b;
        @(posedge i_mclk);
        led_src <= s;
        repeat (3) @(posedge i_mclk);
        #1;
        `CHK("first led", led_exp(codes[c], s), first_led)
        `CHK("second led", led_exp(hi, s), second_led)
      end
    end
    // Link with activity blinks at the shortened half period
    mac.mdio_write(PHY_ADDR, REG_LED, 16'h0088);
    @(posedge i_mclk);
    led_src <= 5'b11000;
    ones = 0;
    repeat (4) @(posedge i_mclk);
    repeat (16) begin
      @(posedge i_mclk);
      #1;
      ones += int'(first_led);
    end
    `CHK("blink on count", 8, ones)
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    i_resetn = 1'b0;
    an_fail = 1'b0;
    an_stat = '0;
    led_src = '0;
    err_total = 0;
    checks = 0;
    repeat (2) @(posedge i_mclk);
    i_resetn <= 1'b1;
    repeat (2) @(posedge i_mclk);
    t_reset();
    t_write();
    t_diag();
    t_led();
    give_verdict();
  end

  initial begin
    repeat (40000) @(posedge i_mclk);
    err_total++;
    give_verdict();
  end
endmodule
